// ---- mpc_carrier_model.sv ----
`timescale 1ns/1ps
// Carrier side: power good and the button both rest on pull-ups when left alone.
module mpc_carrier_model (
  input wire logic hold_low,     // Carrier holds power good low.
  input wire logic press,        // Operator holds the button down.
  input wire logic supply_on_n,  // Supply request from the module.
  output logic supply_good_in,   // Power good seen by the module.
  output logic power_button_n,   // Button level seen by the module.
  output logic supply_enable     // Inverted request at the supply.
);
  // Held low until rails settle, then floated so the pull-up wins.
  assign supply_good_in = hold_low ? 1'b0 : 1'b1;
  // Debounced button to ground; the pull-up gives high when idle.
  assign power_button_n = ~press;
  // Standby-powered inverter in front of the supply enable.
  assign supply_enable = ~supply_on_n;
endmodule : mpc_carrier_model

// ---- mpc_pkg.sv ----
package mpc_pkg;

  // Power sequencer states.
  typedef enum logic [2:0] {
    ST_RESET   = 3'h0,  // Module held in reset.
    ST_SEQ     = 3'h1,  // Onboard power-up sequencing running.
    ST_RUN     = 3'h2,  // Module released and running.
    ST_OFF     = 3'h3   // Operator asked for power off.
  } mpc_state_type;

  // Synchronised carrier inputs travel together.
  typedef struct packed {
    logic supply_good;   // Power good, high means rails are good.
    logic button_n;      // Power button, active low.
  } mpc_inputs_type;

  // Sequencing time per step, in nanoseconds.
  localparam int SEQ_STEP_NS = 1000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SEQ_STEP_CYCLES = (SEQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEQ_CNT_W = 8;
  localparam logic [SEQ_CNT_W-1:0] SEQ_CNT_LAST = SEQ_CNT_W'(SEQ_STEP_CYCLES - 1);
  localparam logic [SEQ_CNT_W-1:0] SEQ_CNT_ZERO = 8'h00;
  localparam logic [SEQ_CNT_W-1:0] SEQ_CNT_ONE = 8'h01;

endpackage : mpc_pkg

// ---- mpc_power_control.sv ----
`timescale 1ns/1ps
// How it works
// RULE1: Power good high starts onboard sequencing.
// RULE2: Held in reset while power good low.
// RULE3: Carrier keeps power good low until stable.
// RULE4: Carrier delays power good about 100ms.
// RULE5: Carrier drives low, then floats power good.
// RULE6: Undriven power good still completes sequencing.
// RULE7: Active-low output requests supply main outputs.
// RULE8: Carrier inverts supply-on before supply enable.
// RULE9: Carrier supplies debounced active-low button level.
// RULE10: Button press toggles power on or off.
// RULE11: Link output is AND of speed indicators.
// RULE12: No link indication at 10 Mb.
// RULE13: Carrier inputs synchronised before any use.
module mpc_power_control
  import mpc_pkg::*;
(
  input wire logic clk_sys,          // System clock, 50 MHz.
  input wire logic reset,            // Asynchronous reset, active high.
  input wire logic supply_good_in,   // Power good from carrier, pulled high when undriven.
  input wire logic power_button_n,   // Debounced power button, active low.
  input wire logic eth_link_fast_n,  // 100 Mb link indicator, active low.
  input wire logic eth_link_gig_n,   // 1 Gb link indicator, active low.
  output logic supply_on_n,          // Supply main outputs request, active low.
  output logic module_reset_n,       // Module reset, active low.
  output logic eth_link_any_n        // Combined link indicator, active low.
);

  // Two-stage synchronisers; the first stage is read only by the second.
  mpc_inputs_type sync1_reg, sync1_next;  // First synchroniser stage.
  mpc_inputs_type sync2_reg, sync2_next;  // Second synchroniser stage, safe to use.
  logic button_last_reg, button_last_next;  // Previous button level for edge detect.
  mpc_state_type state_reg, state_next;   // Sequencer state.
  logic [SEQ_CNT_W-1:0] cnt_reg, cnt_next;  // Sequencing step timer.
  logic supply_on_n_reg, supply_on_n_next;  // Registered supply request.
  logic rst_n_reg, rst_n_next;            // Registered module reset.
  logic link_reg, link_next;              // Registered combined link.
  logic press;                            // One-cycle button press event.

  // Synchroniser next values.
  always_comb begin
    sync1_next = '{supply_good: supply_good_in, button_n: power_button_n}; // RULE13
    sync2_next = sync1_reg;  // RULE13
    // The button history feeds the edge detector below.
    button_last_next = sync2_reg.button_n;
  end

  // Synchroniser registers; idle levels assume no power and a released button.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync1_reg <= '{supply_good: 1'b0, button_n: 1'b1};
      sync2_reg <= '{supply_good: 1'b0, button_n: 1'b1};
      button_last_reg <= 1'b1;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      button_last_reg <= button_last_next;
    end
  end

  // A press is the falling edge of the synchronised button level.
  // The history resets to the released level, so leaving reset never makes a false press.
  assign press = button_last_reg & ~sync2_reg.button_n;  // RULE10

  // Sequencer next-state logic.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    supply_on_n_next = 1'b1;
    rst_n_next = 1'b0;
    case (state_reg)
      ST_RESET: begin
        // Low power good keeps everything held; the pull-up makes an open pin count as good.
        cnt_next = SEQ_CNT_ZERO;
        if (sync2_reg.supply_good) begin
          state_next = ST_SEQ;  // RULE1 RULE6
        end
      end
      ST_SEQ: begin
        // Supply requested first, reset released only after the step timer.
        supply_on_n_next = 1'b0;  // RULE7
        cnt_next = cnt_reg + SEQ_CNT_ONE;
        if (cnt_reg == SEQ_CNT_LAST) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        // Module runs with reset released; a press asks for power off.
        supply_on_n_next = 1'b0;  // RULE7
        rst_n_next = 1'b1;
        if (press) begin
          state_next = ST_OFF;  // RULE10
        end
      end
      ST_OFF: begin
        // Staying off until the next press; firmware policy could change this response.
        if (press) begin
          state_next = ST_RESET;  // RULE10
        end
      end
      default: begin
        // Unused state codes fall back to the held state.
        state_next = ST_RESET;
      end
    endcase
    // Power good low overrides every state except ST_OFF and holds reset.
    // The supply request lingers one more cycle; only the module reset must drop at once.
    if (!sync2_reg.supply_good && state_reg != ST_OFF) begin
      state_next = ST_RESET;  // RULE2
      rst_n_next = 1'b0;  // RULE2
    end
    // Active-low AND: either speed's link low makes the output low; 10 Mb shows none.
    link_next = eth_link_fast_n & eth_link_gig_n;  // RULE11 RULE12
  end

  // Sequencer registers.
  // This process only registers; every decision is made in the process above.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= ST_RESET;
      cnt_reg <= SEQ_CNT_ZERO;
      supply_on_n_reg <= 1'b1;
      rst_n_reg <= 1'b0;
      link_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      supply_on_n_reg <= supply_on_n_next;
      rst_n_reg <= rst_n_next;
      link_reg <= link_next;
    end
  end

  // Every output comes straight from its register, so the carrier never sees a decode glitch.
  assign supply_on_n = supply_on_n_reg;
  assign module_reset_n = rst_n_reg;
  assign eth_link_any_n = link_reg;

  // The checks below watch the registered outputs one edge after the state that drives them.
  // They are disabled during reset, so no check starts from the reset values of the pins.

  // Reset stays asserted one cycle after power good is seen low.
  a_reset_held: assert property (@(posedge clk_sys) disable iff (reset)  // RULE2
    !sync2_reg.supply_good && state_reg != ST_OFF |=> !module_reset_n)
    else $error("Module reset released while power good low.");

  // Power good seen in the held state starts sequencing on the next edge.
  a_seq_start: assert property (@(posedge clk_sys) disable iff (reset)  // RULE1
    state_reg == ST_RESET && sync2_reg.supply_good |=> state_reg == ST_SEQ)
    else $error("Sequencing did not start on power good.");

  // Supply request low during sequencing.
  a_supply_on: assert property (@(posedge clk_sys) disable iff (reset)  // RULE7
    state_reg == ST_SEQ |=> !supply_on_n)
    else $error("Supply request not asserted during sequencing.");

  // A press while running turns power off.
  a_button_off: assert property (@(posedge clk_sys) disable iff (reset)  // RULE10
    state_reg == ST_RUN && press && sync2_reg.supply_good |=> state_reg == ST_OFF)
    else $error("Button press did not request power off.");

  // Combined link follows the AND of both indicators one cycle later.
  a_link_and: assert property (@(posedge clk_sys) disable iff (reset)  // RULE11
    1'b1 |=> eth_link_any_n == ($past(eth_link_fast_n) & $past(eth_link_gig_n)))
    else $error("Combined link is not the AND of speed indicators.");

  // Both indicators idle means no link shown.
  a_link_slow: assert property (@(posedge clk_sys) disable iff (reset)  // RULE12
    eth_link_fast_n && eth_link_gig_n |=> eth_link_any_n)
    else $error("Link shown without fast or gigabit link.");

  // Synchronised power good lags the pin by two cycles.
  a_sync_delay: assert property (@(posedge clk_sys) disable iff (reset)  // RULE13
    1'b1 |-> ##2 sync2_reg.supply_good == $past(supply_good_in, 2))
    else $error("Power good synchroniser delay wrong.");

  // Synchronised button lags the pin by two cycles.
  a_sync_button: assert property (@(posedge clk_sys) disable iff (reset)  // RULE13
    1'b1 |-> ##2 sync2_reg.button_n == $past(power_button_n, 2))
    else $error("Button synchroniser delay wrong.");

  // Stable power good completes sequencing and releases reset in bounded time.
  // The window leaves room for the whole step and the output register.
  a_seq_done: assert property (@(posedge clk_sys) disable iff (reset)  // RULE6
    (state_reg == ST_SEQ && cnt_reg == SEQ_CNT_ZERO && sync2_reg.supply_good)
    ##1 sync2_reg.supply_good [*7]
    |-> ##[1:60] (module_reset_n || !sync2_reg.supply_good))
    else $error("Sequencing did not complete.");

  // The last step of the timer moves the sequencer to the running state.
  a_seq_exit: assert property (@(posedge clk_sys) disable iff (reset)  // RULE1
    state_reg == ST_SEQ && cnt_reg == SEQ_CNT_LAST && sync2_reg.supply_good
    |=> state_reg == ST_RUN)
    else $error("Sequencing did not end after its last step.");

  // The module stays in reset while sequencing runs.
  a_seq_held: assert property (@(posedge clk_sys) disable iff (reset)  // RULE1
    state_reg == ST_SEQ |=> !module_reset_n)
    else $error("Module reset released before sequencing ended.");

  // Running with good power releases the module reset.
  a_run_release: assert property (@(posedge clk_sys) disable iff (reset)  // RULE1
    state_reg == ST_RUN && sync2_reg.supply_good |=> module_reset_n)
    else $error("Module reset not released while running.");

  // Running keeps the supply requested.
  a_run_supply: assert property (@(posedge clk_sys) disable iff (reset)  // RULE7
    state_reg == ST_RUN |=> !supply_on_n)
    else $error("Supply request dropped while running.");

  // The held state keeps the supply off and the module in reset.
  a_reset_outputs: assert property (@(posedge clk_sys) disable iff (reset)  // RULE2
    state_reg == ST_RESET |=> supply_on_n && !module_reset_n)
    else $error("Outputs not held while in reset.");

  // The off state keeps the supply off and the module in reset.
  a_off_outputs: assert property (@(posedge clk_sys) disable iff (reset)  // RULE10
    state_reg == ST_OFF |=> supply_on_n && !module_reset_n)
    else $error("Outputs not off after a power off request.");

  // A press while off asks for power on again.
  a_button_on: assert property (@(posedge clk_sys) disable iff (reset)  // RULE10
    state_reg == ST_OFF && press |=> state_reg == ST_RESET)
    else $error("Button press did not request power on.");

endmodule : mpc_power_control

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import mpc_pkg::*;
  logic clk_sys, reset, hold_low, press, fast_n, gig_n, exp_link;
  logic supply_good_in, power_button_n, supply_on_n, module_reset_n, eth_link_any_n;
  logic [7:0] lfsr;  // Random source for the link lines.
  int fail_count, compares, cycles, n;
  logic supply_enable, g, b, hit, btn_old, m_sup_n, m_rst_n;  // Carrier supply enable and reference model state.
  logic good_q[$], btn_q[$];  // Pin history standing for the two synchroniser stages.
  int m_state, m_cnt;  // Model state: 0 held, 1 sequencing, 2 running, 3 off.
  mpc_carrier_model carrier (.hold_low(hold_low), .press(press), .supply_on_n(supply_on_n),
    .supply_good_in(supply_good_in), .power_button_n(power_button_n),
    .supply_enable(supply_enable));
  mpc_power_control dut (.clk_sys(clk_sys), .reset(reset), .supply_good_in(supply_good_in),
    .power_button_n(power_button_n), .eth_link_fast_n(fast_n), .eth_link_gig_n(gig_n),
    .supply_on_n(supply_on_n), .module_reset_n(module_reset_n),
    .eth_link_any_n(eth_link_any_n));
  // Closes the run with the verdict.
  task summarize;
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // Compares one value and reports a mismatch.
  task check(input string name, input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0b seen %0b", name, exp, seen);
    end
  endtask : check
  // Advances k edges and lands just after the last one.
  task step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : step
  // Eight-bit shift register for random link patterns.
  function automatic logic [7:0] next_lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : next_lfsr
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Link lines take fresh random values every cycle.
  always @(posedge clk_sys) begin
    #1 lfsr = next_lfsr(lfsr);
    fast_n = lfsr[0];
    gig_n = lfsr[1];
  end
  // Reference: combined link is the AND of both speeds, one register late.
  always @(posedge clk_sys or posedge reset) exp_link <= reset ? 1'b1 : (fast_n & gig_n);
  // Reference sequencer written from the rules; outputs follow the state one edge late.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      good_q = '{1'b0, 1'b0};
      btn_q = '{1'b1, 1'b1};
      btn_old = 1'b1;
      m_state = 0;
      m_cnt = 0;
      m_sup_n = 1'b1;
      m_rst_n = 1'b0;
    end else begin
      g = good_q.pop_front();
      b = btn_q.pop_front();
      good_q.push_back(supply_good_in);
      btn_q.push_back(power_button_n);
      hit = btn_old & ~b;
      btn_old = b;
      m_sup_n = !(m_state == 1 || m_state == 2);
      m_rst_n = m_state == 2 && g;
      m_cnt = (m_state == 1) ? m_cnt + 1 : 0;
      if (!g && m_state != 3) begin
        m_state = 0;
      end else begin
        case (m_state)
          0: m_state = g ? 1 : 0;
          1: m_state = (m_cnt == SEQ_STEP_CYCLES) ? 2 : 1;
          2: m_state = hit ? 3 : 2;
          default: m_state = hit ? 0 : 3;
        endcase
      end
    end
  end
  // Every reference-model result is compared at the falling edge, where the outputs have settled.
  always @(negedge clk_sys) begin
    check("link", eth_link_any_n, exp_link);
    check("supply", supply_on_n, m_sup_n);
    check("module reset", module_reset_n, m_rst_n);
    check("supply enable", supply_enable, ~m_sup_n);
  end
  // Hang guard, far above the expected run length.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      summarize;
    end
  end
  initial begin
    exp_link = 1'b1;
    reset = 1'b1;
    hold_low = 1'b1;
    press = 1'b0;
    fast_n = 1'b1;
    gig_n = 1'b1;
    lfsr = 8'h5a;
    step(6);
    reset = 1'b0;
    step(20);
    check("reset held", module_reset_n, 1'b0);
    check("supply off", supply_on_n, 1'b1);
    hold_low = 1'b0;
    step(6);
    check("supply on", supply_on_n, 1'b0);
    n = 0;
    while (module_reset_n !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    // Two sync edges, one state edge, the step and the output edge, less six stepped edges.
    check("seq len", n == SEQ_STEP_CYCLES - 2, 1'b1);
    press = 1'b1;
    step(6);
    press = 1'b0;
    step(10);
    check("off supply", supply_on_n, 1'b1);
    check("off reset", module_reset_n, 1'b0);
    press = 1'b1;
    step(6);
    press = 1'b0;
    step(6);
    check("on again", supply_on_n, 1'b0);
    step(60);
    check("run again", module_reset_n, 1'b1);
    hold_low = 1'b1;
    step(2);
    check("sync delay", module_reset_n, 1'b1);
    step(1);
    check("drop reset", module_reset_n, 1'b0);
    step(1);
    check("drop supply", supply_on_n, 1'b1);
    summarize;
  end
endmodule : tb_top
